// >>> verif/tb_top.sv
// testbench for the output and converter register slice
// assumes the host model as bus master and the bench driving the clear and clamp pins
`timescale 1ns/1ps
`default_nettype none

module tb_top;

	logic mclk, rst_n, cyc, stb, we, ack, hwClear, ok;
	logic [7:0] adr;
	logic [3:0] sel, channelIsCurrent, channelStepOn;
	logic [31:0] datW, datR, rdata;
	logic [15:0] autoPosClamp, channelSpan;
	logic [63:0] channelCode, converterConfig;
	logic [3:0] spans [5];
	int bad_count;
	int compares;

	always #2 mclk = ~mclk;

	dac_output_and_converter_regs #(.ADDR_WIDTH(8)) dac_output_and_converter_regs_i (
		.mclk(mclk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack), .hwClear(hwClear),
		.autoPosClamp(autoPosClamp), .channelCode(channelCode), .channelSpan(channelSpan),
		.channelIsCurrent(channelIsCurrent), .channelStepOn(channelStepOn),
		.converterConfig(converterConfig)
	);

	wb_host_model wb_host_model_i (
		.mclk(mclk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
		.datW(datW), .datR(datR), .ack(ack)
	);

	////////////////////////////////////////////////////////////////////////
	// checking and closing
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude

	// a missing ack ends the run at once rather than cascading
	task automatic bus(input logic write, input logic [5:0] idx, input logic [15:0] d);
		wb_host_model_i.access(write, idx, d, rdata, ok);
		if (ok !== 1'b1) begin
			bad_count++;
			$display("ERROR ack expected 1 seen 0");
			conclude();
		end
	endtask : bus

	task automatic wr(input logic [5:0] idx, input logic [15:0] d);
		bus(1'b1, idx, d);
	endtask : wr

	task automatic rd(input logic [5:0] idx, input logic [15:0] exp, input string what);
		bus(1'b0, idx, 16'h0000);
		chk(what, {32'h0000_0000, 16'h0000, exp}, {32'h0000_0000, rdata});
	endtask : rd

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		hwClear = 1'b0;
		autoPosClamp = 16'h0000;
		bad_count = 0;
		compares = 0;
		spans = '{4'h1, 4'h4, 4'h6, 4'h7, 4'h0};
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		// reset state of every word and output
		for (int i = 3; i <= 8; i++) rd(6'(i), 16'h0000, "reset word");
		chk("reset code", 64'h0000_0000_0000_0000, channelCode);
		chk("reset span", 64'h0000_0000_0000_0000, {48'h0, channelSpan});
		chk("reset current", 64'h0000_0000_0000_0000, {60'h0, channelIsCurrent});
		chk("reset step", 64'h0000_0000_0000_0000, {60'h0, channelStepOn});
		chk("reset conv", 64'h0000_0000_0000_0000, converterConfig);
		$display("test reset done");
		// converter select with reserved bits, then clamp modes on A and C
		wr(6'h06, 16'hFFF5);
		rd(6'h06, 16'hFFF5, "converter select");
		wr(6'h07, 16'h0400);
		wr(6'h07, 16'hF7FF);
		chk("conv user", 64'h0000_F7FF_0000_F7FF, converterConfig);
		rd(6'h07, 16'hF7FF, "conv readback");
		wr(6'h07, 16'h03FF);
		wr(6'h07, 16'h0000);
		chk("conv track lock", 64'h0000_03FC_0000_03FC, converterConfig);
		@(posedge mclk);
		autoPosClamp <= 16'h0503;
		wr(6'h07, 16'h0BFC);
		repeat (6) @(posedge mclk);
		chk("conv auto", 64'h0000_097C_0000_08FC, converterConfig);
		wr(6'h07, 16'h0C00);
		chk("conv mode 11", 64'h0000_0000_0000_00FC, {56'h0, converterConfig[11:10], converterConfig[5:0]});
		$display("test converter done");
		// pick B and D, B clears to mid scale
		wr(6'h03, 16'h0540);
		rd(6'h03, 16'h0540, "channel select");
		wr(6'h05, 16'h1234);
		chk("code fanout", 64'h1234_0000_1234_0000, channelCode);
		rd(6'h05, 16'h1234, "code readback");
		wr(6'h04, 16'h0015);
		chk("step on", 64'h0000_0000_0000_000A, {60'h0, channelStepOn});
		chk("span 0101", 64'h0000_0000_0000_5050, {48'h0, channelSpan});
		chk("span change code", 64'h0000_0000_8000_0000, channelCode);
		// every span change reloads the clear target; codes 01xx are current
		for (int k = 0; k < 5; k++) begin
			wr(6'h05, 16'hABCD);
			wr(6'h04, {12'h000, spans[k]});
			chk("span", {48'h0, spans[k], 4'h0, spans[k], 4'h0}, {48'h0, channelSpan});
			chk("current", {60'h0, spans[k][2], 1'b0, spans[k][2], 1'b0}, {60'h0, channelIsCurrent});
			chk("span code", 64'h0000_0000_8000_0000, channelCode);
			chk("step off", 64'h0000_0000_0000_0000, {60'h0, channelStepOn});
		end
		wr(6'h05, 16'hABCD);
		wr(6'h04, 16'h0000);
		chk("same span keeps", 64'hABCD_0000_ABCD_0000, channelCode);
		$display("test channel done");
		// software clear, then hardware clear
		wr(6'h08, 16'h0001);
		chk("soft clear", 64'h0000_0000_8000_0000, channelCode);
		wr(6'h05, 16'h4321);
		@(posedge mclk);
		hwClear <= 1'b1;
		repeat (5) @(posedge mclk);
		chk("hard clear", 64'h0000_0000_8000_0000, channelCode);
		hwClear <= 1'b0;
		// unmapped word is acked, reads zero, keeps nothing
		wr(6'h3F, 16'hFFFF);
		rd(6'h3F, 16'h0000, "unmapped");
		// only channel A picked: B keeps its mid-scale code
		wr(6'h03, 16'h0020);
		wr(6'h05, 16'h5A5A);
		chk("code pick A", 64'h0000_0000_8000_5A5A, channelCode);
		rd(6'h05, 16'h5A5A, "code A readback");
		$display("test clear done");
		conclude();
	end

endmodule : tb_top

`default_nettype wire

// >>> verif/wb_host_model.sv
// host side model: a classic Wishbone master issuing single register accesses
// assumes a slave on the same clock that answers each request with one ack
`timescale 1ns/1ps
`default_nettype none

module wb_host_model (
	input wire logic mclk,
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] datW,
	input wire logic [31:0] datR,
	input wire logic ack
);

	////////////////////////////////////////////////////////////////////////
	// idle bus from time zero
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		datW = 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////
	// host reads and writes
	// one access: raise after an edge, hold until ack is sampled, then release;
	// cyc, stb and we drop to zero; address, select and data are inverted so a slave latching late sees garbage
	task automatic access(input logic write, input logic [5:0] idx, input logic [15:0] data,
		output logic [31:0] rdata, output logic ok);
		int n;
		ok = 1'b0;
		rdata = 32'h0000_0000;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= write;
		adr <= {idx, 2'h0};
		sel <= 4'h3;
		datW <= {16'h0000, data};
		for (n = 0; n < 16 && !ok; n++) begin
			@(posedge mclk);
			if (ack === 1'b1) begin
				ok = 1'b1;
				rdata = datR;
			end
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		adr <= ~adr;
		sel <= ~sel;
		datW <= ~datW;
	endtask : access

endmodule : wb_host_model

`default_nettype wire

// >>> verilog/dac_channel_slot.sv
// one output channel: configuration word and conversion code
// assumes write strobes and clear pulses come from logic on mclk
`timescale 1ns/1ps
`default_nettype none
`include "dac_regs_map.svh"

module dac_channel_slot (
	input wire logic mclk,
	input wire logic rstSync_n,
	input wire logic cfgWrite,
	input wire logic codeWrite,
	input wire logic [15:0] wrData,
	input wire logic [15:0] wrMask,
	input wire logic clearEvent,
	input wire logic clearToMid,
	output logic [15:0] channelConfig,
	output logic [15:0] conversionCode,
	output logic isCurrent
);

	logic [15:0] cfgMerged;
	logic [15:0] cfg_next;
	logic spanChanged;
	logic [15:0] clearValue;

	////////////////////////////////////////////////////////////////////////////////
	// next values

	// byte-lane merge keeps the lanes that the master left unselected
	always_comb begin
		cfgMerged = (channelConfig & ~wrMask) | (wrData & wrMask);
		cfg_next = cfgWrite ? cfgMerged : channelConfig;
		spanChanged = cfgWrite && (cfgMerged[`POS_SPAN_LO +: 4] != channelConfig[`POS_SPAN_LO +: 4]);
		clearValue = clearToMid ? `CODE_MID_SCALE : `CODE_ZERO_SCALE;
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	// step enable and span storage; span resets to 0000, the 0..5 V range
	always_ff @(posedge mclk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			channelConfig <= `RST_WORD;
		end else begin
			channelConfig <= cfg_next;
		end
	end

	// span change reloads code; a clear beats a same-cycle code write
	always_ff @(posedge mclk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			conversionCode <= `RST_WORD;
		end else if (clearEvent || spanChanged) begin
			conversionCode <= clearValue;
		end else if (codeWrite) begin
			conversionCode <= (conversionCode & ~wrMask) | (wrData & wrMask);
		end
	end

	// current or voltage output, kept in step with the span
	always_ff @(posedge mclk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			isCurrent <= 1'b0;
		end else begin
			isCurrent <= dac_regs_pkg::span_is_current(cfg_next[`POS_SPAN_LO +: 4]);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking @(posedge mclk); endclocking
	default disable iff (!rstSync_n);

	sequence s_span_change;
		cfgWrite && (cfgMerged[3:0] != channelConfig[3:0]) && !clearEvent;
	endsequence

	a_span_clear: assert property (s_span_change |=> conversionCode == ($past(clearToMid) ? 16'h8000 : 16'h0000))
		else $error("span change did not load the clear value");

	a_clear_zero: assert property (clearEvent && !clearToMid |=> conversionCode == 16'h0000)
		else $error("clear did not reach zero scale");

	a_clear_mid: assert property (clearEvent && clearToMid |=> conversionCode == 16'h8000)
		else $error("clear did not reach mid scale");

	a_step_toggle: assert property (cfgWrite && wrMask[4] |=> channelConfig[4] == $past(wrData[4]))
		else $error("step enable not taken from the write");

	a_span_voltage: assert property (channelConfig[3:1] == 3'h0 |-> !isCurrent)
		else $error("span 0000 or 0001 shown as current");

	a_span_current: assert property (channelConfig[3:2] == 2'h1 |-> isCurrent)
		else $error("span 01xx not shown as current");

endmodule : dac_channel_slot

`default_nettype wire

// >>> verilog/dac_output_and_converter_regs.sv
// output and converter register slice of a four-channel converter, Wishbone classic slave
// assumes a 32-bit Wishbone master on mclk; hwClear and autoPosClamp are asynchronous pins
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dac_regs_map.svh"

module dac_output_and_converter_regs #(
	parameter int ADDR_WIDTH = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADDR_WIDTH-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic hwClear,
	input wire logic [15:0] autoPosClamp,
	output logic [63:0] channelCode,
	output logic [15:0] channelSpan,
	output logic [3:0] channelIsCurrent,
	output logic [3:0] channelStepOn,
	output logic [63:0] converterConfig
);

	localparam int CHANNELS = 4;

	// the decode needs byte address bits 7:2
	if (ADDR_WIDTH < 8) begin : g_addr_check
		$error("ADDR_WIDTH must be at least 8");
	end

	////////////////////////////////////////////////////////////////////////////////
	// reset and pin synchronisers

	logic [1:0] rstPipe_reg;
	logic rstSync_n;
	logic clearMeta_reg;
	logic clearSync_reg;
	logic clearLast_reg;
	logic [15:0] autoMeta_reg;
	logic [15:0] autoSync_reg;

	// assert asynchronously, release after two edges
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rstPipe_reg <= 2'h0;
		end else begin
			rstPipe_reg <= {rstPipe_reg[0], 1'b1};
		end
	end
	assign rstSync_n = rstPipe_reg[1];

	// hardware clear pin: two flops, then an edge detector on the second
	always_ff @(posedge mclk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			clearMeta_reg <= 1'b0;
			clearSync_reg <= 1'b0;
			clearLast_reg <= 1'b0;
		end else begin
			clearMeta_reg <= hwClear;
			clearSync_reg <= clearMeta_reg;
			clearLast_reg <= clearSync_reg;
		end
	end

	// auto-learned clamp levels; a bus of slow levels, so bit skew lasts one cycle at most
	always_ff @(posedge mclk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			autoMeta_reg <= `RST_WORD;
			autoSync_reg <= `RST_WORD;
		end else begin
			autoMeta_reg <= autoPosClamp;
			autoSync_reg <= autoMeta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus decode

	logic ack_reg;
	logic [31:0] readData_reg;
	logic [5:0] regIdx;
	logic wrAccept;
	logic rdAccept;
	logic [15:0] wrData;
	logic [15:0] wrMask;
	logic softClear;
	logic clearPulse;

	// upper address bits above 7 alias onto the same map
	assign regIdx = adr_i[7:2];
	assign wrAccept = cyc_i && stb_i && we_i && !ack_reg;
	assign rdAccept = cyc_i && stb_i && !we_i && !ack_reg;
	assign wrData = dat_i[15:0];
	assign wrMask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
	assign softClear = wrAccept && (regIdx == `IDX_SOFT_CLEAR) && sel_i[0] && dat_i[`POS_SOFT_CLEAR];
	assign clearPulse = softClear || (clearSync_reg && !clearLast_reg);

	// one wait state: ack one cycle after the strobe, dropped the cycle after
	always_ff @(posedge mclk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= cyc_i && stb_i && !ack_reg;
		end
	end
	assign ack_o = ack_reg;

	////////////////////////////////////////////////////////////////////////////////
	// select registers

	logic [15:0] chanSelect_reg;
	logic [15:0] converterSelect_reg;
	logic [3:0] chanPick;
	logic [3:0] clearSel;
	logic [3:0] converterPick;

	// channel picks and clear targets; other bits of this word read zero
	always_ff @(posedge mclk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			chanSelect_reg <= `RST_WORD;
		end else if (wrAccept && regIdx == `IDX_CHANNEL_SELECT) begin
			chanSelect_reg <= ((chanSelect_reg & ~wrMask) | (wrData & wrMask)) & `MASK_CHANNEL_SELECT;
		end
	end
	assign chanPick = chanSelect_reg[`POS_CHAN_PICK_LO +: 4];
	assign clearSel = chanSelect_reg[`POS_CLEAR_SEL_LO +: 4];

	// converter picks plus writable reserved bits
	always_ff @(posedge mclk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			converterSelect_reg <= `RST_WORD;
		end else if (wrAccept && regIdx == `IDX_CONVERTER_SELECT) begin
			converterSelect_reg <= (converterSelect_reg & ~wrMask) | (wrData & wrMask);
		end
	end
	assign converterPick = converterSelect_reg[3:0];

	////////////////////////////////////////////////////////////////////////////////
	// channels and converters

	logic [15:0] chanCfg [CHANNELS];
	logic [15:0] convCfg_reg [CHANNELS];

	for (genvar k = 0; k < CHANNELS; k++) begin : g_unit
		logic cfgWrite;
		logic codeWrite;
		logic convWrite;
		logic [15:0] convMerged;
		logic [15:0] keepMask;
		logic [15:0] conv_next;

		// a write reaches every picked channel
		assign cfgWrite = wrAccept && (regIdx == `IDX_CHANNEL_CONFIG) && chanPick[k];
		assign codeWrite = wrAccept && (regIdx == `IDX_CONVERSION_CODE) && chanPick[k];

		dac_channel_slot u_slot (
			.mclk(mclk),
			.rstSync_n(rstSync_n),
			.cfgWrite(cfgWrite),
			.codeWrite(codeWrite),
			.wrData(wrData),
			.wrMask(wrMask),
			.clearEvent(clearPulse),
			.clearToMid(clearSel[k]),
			.channelConfig(chanCfg[k]),
			.conversionCode(channelCode[16*k +: 16]),
			.isCurrent(channelIsCurrent[k])
		);

		assign channelSpan[4*k +: 4] = chanCfg[k][`POS_SPAN_LO +: 4];
		assign channelStepOn[k] = chanCfg[k][`POS_STEP_ON];

		// clamp fields writable only in user mode; mode 11 locks them too
		always_comb begin
			convWrite = wrAccept && (regIdx == `IDX_CONVERTER_CONFIG) && converterPick[k];
			convMerged = (convCfg_reg[k] & ~wrMask) | (wrData & wrMask);
			if (convCfg_reg[k][`POS_CLAMP_MODE_LO +: 2] == dac_regs_pkg::CLAMP_USER) begin
				keepMask = `RST_WORD;
			end else begin
				keepMask = `MASK_POS_CLAMP | `MASK_NEG_CLAMP;
			end
			conv_next = convWrite ? ((convMerged & ~keepMask) | (convCfg_reg[k] & keepMask)) : convCfg_reg[k];
			// auto mode refills the positive clamp every cycle
			if (convCfg_reg[k][`POS_CLAMP_MODE_LO +: 2] == dac_regs_pkg::CLAMP_AUTO) begin
				conv_next[`POS_POS_CLAMP_LO +: 4] = autoSync_reg[4*k +: 4];
			end
		end

		always_ff @(posedge mclk or negedge rstSync_n) begin
			if (!rstSync_n) begin
				convCfg_reg[k] <= `RST_WORD;
			end else begin
				convCfg_reg[k] <= conv_next;
			end
		end
		assign converterConfig[16*k +: 16] = convCfg_reg[k];
	end

	////////////////////////////////////////////////////////////////////////////////
	// readback

	logic [1:0] readChan;
	logic [1:0] readConv;
	logic [15:0] readWord;

	// shared registers read back from the lowest picked unit, unit A if none
	always_comb begin
		readChan = 2'h0;
		readConv = 2'h0;
		for (int i = CHANNELS - 1; i >= 0; i--) begin
			if (chanPick[i]) begin
				readChan = 2'(i);
			end
			if (converterPick[i]) begin
				readConv = 2'(i);
			end
		end
	end

	// unmapped indices read zero and ignore writes
	always_comb begin
		case (regIdx)
			`IDX_CHANNEL_SELECT: readWord = chanSelect_reg;
			`IDX_CHANNEL_CONFIG: readWord = chanCfg[readChan];
			`IDX_CONVERSION_CODE: readWord = channelCode[16*readChan +: 16];
			`IDX_CONVERTER_SELECT: readWord = converterSelect_reg;
			`IDX_CONVERTER_CONFIG: readWord = convCfg_reg[readConv];
			default: readWord = `RST_WORD;
		endcase
	end

	// data is captured with the ack and held until the next read
	always_ff @(posedge mclk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			readData_reg <= `RST_READ;
		end else if (rdAccept) begin
			readData_reg <= {16'h0000, readWord};
		end
	end
	assign dat_o = readData_reg;

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking @(posedge mclk); endclocking
	default disable iff (!rstSync_n);

	sequence s_full_write(logic [5:0] idx);
		wrAccept && (regIdx == idx) && (sel_i[1:0] == 2'h3);
	endsequence

	sequence s_code_read_a;
		rdAccept && (regIdx == 6'h05) && (readChan == 2'h0);
	endsequence

	sequence s_code_write_a;
		s_full_write(6'h05) ##0 (chanPick[0] && !clearPulse);
	endsequence

	// a write that skips a unit must leave that unit alone
	sequence s_code_skip_b;
		wrAccept && (regIdx == 6'h05) && !chanPick[1] && !clearPulse;
	endsequence

	sequence s_cfg_skip_a;
		wrAccept && (regIdx == 6'h04) && !chanPick[0];
	endsequence

	// converter B in auto mode refills its own clamp, so that case is left out
	sequence s_conv_skip_b;
		wrAccept && (regIdx == 6'h07) && !converterPick[1] && (converterConfig[27:26] != 2'h2);
	endsequence

	sequence s_conv_write_a;
		s_full_write(6'h07) ##0 converterPick[0];
	endsequence

	sequence s_conv_write_mode(logic [1:0] mode);
		s_conv_write_a ##0 (converterConfig[11:10] == mode);
	endsequence

	sequence s_auto_mode_a;
		converterConfig[11:10] == 2'h2;
	endsequence

	// pin edge seen by the first flop, one step before the clear pulse
	sequence s_clear_pin_rise;
		!clearMeta_reg ##1 clearMeta_reg;
	endsequence

	a_code_write: assert property (s_code_write_a |=> channelCode[15:0] == $past(dat_i[15:0]))
		else $error("code write to channel A lost");

	a_code_read: assert property (s_code_read_a |=> ack_o && dat_o == {16'h0000, $past(channelCode[15:0])})
		else $error("code readback wrong");

	a_conv_pick: assert property (s_full_write(6'h06) |=> converterPick == $past(dat_i[3:0]))
		else $error("converter picks not written");

	a_conv_reserved: assert property (s_full_write(6'h06) |=> converterSelect_reg[15:4] == $past(dat_i[15:4]))
		else $error("reserved select bits not writable");

	a_conv_mode: assert property (s_conv_write_a |=> converterConfig[11:10] == $past(dat_i[11:10]))
		else $error("clamp mode not written");

	a_clamp_lock: assert property (s_conv_write_mode(2'h0) |=> $stable(converterConfig[9:2]))
		else $error("clamp fields written in tracking mode");

	a_user_write: assert property (s_conv_write_mode(2'h1) |=> converterConfig[9:2] == $past(dat_i[9:2]))
		else $error("clamp fields not written in user mode");

	a_auto_fill: assert property (s_auto_mode_a |=> converterConfig[9:6] == $past(autoSync_reg[3:0]))
		else $error("positive clamp not auto-filled");

	a_pick_skip: assert property (s_code_skip_b |=> $stable(channelCode[31:16]))
		else $error("unpicked channel code changed");

	a_cfg_skip: assert property (s_cfg_skip_a |=> $stable(channelSpan[3:0]) && $stable(channelStepOn[0]))
		else $error("unpicked channel config changed");

	a_conv_skip: assert property (s_conv_skip_b |=> $stable(converterConfig[31:16]))
		else $error("unpicked converter config changed");

	a_clear_zero_a: assert property (clearPulse && !clearSel[0] |=> channelCode[15:0] == 16'h0000)
		else $error("clear did not take channel A to zero scale");

	a_pin_clear: assert property (s_clear_pin_rise |=> clearPulse)
		else $error("clear pin edge did not make a clear pulse");

	a_ack_one: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("ack not a single cycle after the strobe");

	a_read_hold: assert property (!rdAccept |=> $stable(dat_o))
		else $error("read data changed without a read");

endmodule : dac_output_and_converter_regs

`default_nettype wire

// >>> verilog/dac_regs_map.svh
// register map of the output and converter register slice
// assumes word-indexed registers on a 32-bit bus, byte address = index * 4
`ifndef DAC_REGS_MAP_SVH
`define DAC_REGS_MAP_SVH

// register indices (byte address is four times the index)
`define IDX_CHANNEL_SELECT 6'h03
`define IDX_CHANNEL_CONFIG 6'h04
`define IDX_CONVERSION_CODE 6'h05
`define IDX_CONVERTER_SELECT 6'h06
`define IDX_CONVERTER_CONFIG 6'h07
`define IDX_SOFT_CLEAR 6'h08

// reset values
`define RST_WORD 16'h0000
`define RST_READ 32'h0000_0000

// clear targets
`define CODE_ZERO_SCALE 16'h0000
`define CODE_MID_SCALE 16'h8000

// channel configuration fields
`define POS_STEP_ON 4
`define POS_SPAN_LO 0

// channel select fields
`define POS_CHAN_PICK_LO 5
`define POS_CLEAR_SEL_LO 9
`define MASK_CHANNEL_SELECT 16'h1FE0

// converter configuration fields
`define POS_CLAMP_MODE_LO 10
`define POS_POS_CLAMP_LO 6
`define POS_NEG_CLAMP_LO 2
`define POS_SIDE_SEL_LO 0
`define MASK_POS_CLAMP 16'h03C0
`define MASK_NEG_CLAMP 16'h003C

// soft clear field
`define POS_SOFT_CLEAR 0

`endif

// >>> verilog/dac_regs_pkg.sv
// types shared by the output and converter register slice
// assumes nothing of its surroundings
`default_nettype none

package dac_regs_pkg;

	// output span codes
	typedef enum logic [3:0] {
		SPAN_V_0_5 = 4'h0,
		SPAN_V_0_10 = 4'h1,
		SPAN_V_PM5 = 4'h2,
		SPAN_V_PM10 = 4'h3,
		SPAN_I_3P5_23P5 = 4'h4,
		SPAN_I_0_20 = 4'h5,
		SPAN_I_0_24 = 4'h6,
		SPAN_I_PM24 = 4'h7,
		SPAN_V_0_6 = 4'h8,
		SPAN_V_0_12 = 4'h9,
		SPAN_V_PM6 = 4'hA,
		SPAN_V_PM12 = 4'hB
	} span_t;

	// converter clamp modes
	typedef enum logic [1:0] {
		CLAMP_TRACK = 2'h0,
		CLAMP_USER = 2'h1,
		CLAMP_AUTO = 2'h2,
		CLAMP_INVALID = 2'h3
	} clamp_mode_t;

	// codes 0100..0111 and 111x drive a current output
	function automatic logic span_is_current(input logic [3:0] span);
		span_is_current = (span[3:2] == 2'h1) || (span[3:1] == 3'h7);
	endfunction : span_is_current

endpackage : dac_regs_pkg

`default_nettype wire
